/* File: pkg/orbst_pkg.sv */
// Purpose: shared constants and types of the octal boundary-scan register
// Assumes: eight data bits, one test port, two clock domains
// Notes:   opcodes other than the reset value are local choices
package orbst_pkg;

    // ------------------------------------------------------------------
    // register lengths and fixed values
    // ------------------------------------------------------------------
    localparam int         IR_LEN     = 8;
    localparam int         BSR_LEN    = 18;
    localparam int         BCR_LEN    = 2;
    localparam int         DATA_W     = 8;
    localparam int         FIFO_DEPTH = 32;
    localparam logic [7:0] IR_RESET   = 8'hff;
    localparam logic [7:0] IR_CAPTURE = 8'h81;
    localparam logic [1:0] BCR_RESET  = 2'h2;

    // ------------------------------------------------------------------
    // instruction opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_BYPASS     = 8'hff; // normal mode, bypass
    localparam logic [7:0] OP_DRIVE_PINS = 8'h00; // test mode, boundary
    localparam logic [7:0] OP_SAMPLE     = 8'h82; // normal mode, boundary
    localparam logic [7:0] OP_CONTROL    = 8'h87; // normal mode, control
    localparam logic [7:0] OP_FLOAT      = 8'h86; // test mode, outputs off
    localparam logic [7:0] OP_HOLD       = 8'h85; // test mode, bypass

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // boundary cells, bit 0 sits next to the serial output
    typedef struct packed {
        logic [7:0] q;
        logic [7:0] d;
        logic       clk;
        logic       oe_n;
    } orbst_bsr_t;

    // normal-function input pins
    typedef struct packed {
        logic       clk;
        logic       oe_n;
        logic [7:0] d;
    } orbst_pins_t;

    // word that the test side hands to the pin side
    typedef struct packed {
        logic       test;
        logic       oe_n;
        logic [7:0] q;
    } orbst_drive_t;

    typedef enum logic [1:0] {
        SEL_BYPASS,
        SEL_BSR,
        SEL_BCR
    } orbst_sel_t;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
        ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR,
        ST_EXIT2_IR, ST_UPD_IR
    } orbst_tap_t;

endpackage

/* File: verilog/orbst_fifo.sv */
// Purpose: single-clock queue of data words with valid/ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes:   any depth of two or more; no first-word fall-through bypass
`timescale 1ns/1ps
`default_nettype none
module orbst_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    // refuse depths that the pointers cannot serve
    if (DEPTH < 2) begin : g_bad_depth
        $error("orbst_fifo: DEPTH must be at least 2");
    end

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0]   count_r;
    logic          push;
    logic          pop;

    // honest flags from the occupancy count
    assign in_ready  = (count_r != FULL);
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage carries no reset, only the pointers and the count need one
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_r] <= in_data;
        end
    end

    // pointers wrap explicitly so depth need not be a power of two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= (wptr_r == LAST) ? '0 : wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= (rptr_r == LAST) ? '0 : rptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

/* File: verilog/orbst_top.sv */
// Purpose: octal edge-triggered register with a boundary-scan test port
// Assumes: ref_clk 100 MHz for the pin side, tck for the test side
// Notes:   normal loads pass a queue, so outputs lag the pin clock edge
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1 - test logic samples on rising test clock, outputs change on falling
// RL2 - serial input feeds instruction or selected data register
// RL3 - serial output shows shifted bit, undriven outside shift states
// RL4 - state machine uses test clock and mode select only; controls decoded
// RL5 - double-high mode select level forces the test logic to reset
// RL6 - instruction register is eight bits, loaded serially
// RL7 - data registers: 18-bit boundary, 2-bit control, 1-bit bypass
// RL8 - tester sends everything over the four-wire serial port
// RL9 - unconnected clock, data and enable inputs read high
// RL10 - eight data in, eight out, own clock and low-active enable
// RL11 - load on rising clock with enable low, hold, float when high
// RL12 - test mode inhibits normal register, test logic owns boundary pins
// RL13 - next state chosen from mode select at each rising test clock
// RL14 - standard sixteen-state controller with reset, idle, both scan arms
// RL15 - scanning in normal mode leaves the normal register untouched
module orbst_top #(
    parameter int FIFO_DEPTH = orbst_pkg::FIFO_DEPTH
) (
    // system clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // normal-function pins
    input  wire logic       norm_clk,
    input  wire logic       norm_oe_n,
    input  wire logic [7:0] parallel_data_inputs,
    output logic      [7:0] parallel_data_outputs,
    output logic            pdo_oe,
    // serial test port
    input  wire logic       tck,
    input  wire logic       tms,
    input  wire logic       tdi,
    input  wire logic       mode_select_double_high_level,
    output logic            tdo,
    output logic            tdo_oe,
    // status
    output logic            test_mode,
    output logic            load_dropped
);
    // ------------------------------------------------------------------
    // elaboration checks and declarations
    // ------------------------------------------------------------------
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("orbst_top: FIFO_DEPTH must be at least 2");
    end

    logic                 ref_rst_s1_r, ref_rst_n;
    logic                 tck_rst_s1_r, tck_rst_n;
    orbst_pkg::orbst_pins_t pin_s1_r, pin_s2_r;
    logic                 nclk_d_r;
    logic                 tgl_s1_r, tgl_s2_r, tgl_s3_r;
    orbst_pkg::orbst_drive_t drv_q_r;
    logic [7:0]           q_r;
    logic                 q_oe_r;
    logic                 test_r;
    logic                 dropped_r;
    logic                 f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [7:0]           f_out_data;
    orbst_pkg::orbst_pins_t tpin_s1_r, tpin_s2_r;
    logic [7:0]           qobs_s1_r, qobs_s2_r;
    logic                 dh_s1_r, dh_s2_r;
    orbst_pkg::orbst_tap_t  state_r, state_nxt;
    orbst_pkg::orbst_sel_t  sel;
    logic [7:0]           ir_sh_r, ir_q_r;
    orbst_pkg::orbst_bsr_t  bsr_sh_r, bsr_upd_r, bsr_cap;
    logic [1:0]           bcr_sh_r, bcr_q_r;
    logic                 byp_sh_r;
    logic                 dr_lsb;
    logic                 tdo_r, tdo_oe_r;
    orbst_pkg::orbst_drive_t drv_r, drv_nxt;
    logic                 tgl_r;
    logic                 is_test_op;

    // ------------------------------------------------------------------
    // reset release, one synchroniser per domain
    // ------------------------------------------------------------------
    // assertion is immediate, release waits for two edges of each clock
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ref_rst_s1_r <= 1'b0;
            ref_rst_n    <= 1'b0;
        end else begin
            ref_rst_s1_r <= 1'b1;
            ref_rst_n    <= ref_rst_s1_r;
        end
    end

    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            tck_rst_s1_r <= 1'b0;
            tck_rst_n    <= 1'b0;
        end else begin
            tck_rst_s1_r <= 1'b1;
            tck_rst_n    <= tck_rst_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // pin side: normal register on ref_clk
    // ------------------------------------------------------------------
    // synchronisers start high so a floating pin reads as high
    always_ff @(posedge ref_clk or negedge ref_rst_n) begin
        if (!ref_rst_n) begin
            pin_s1_r <= '1; // RL9
            pin_s2_r <= '1;
            nclk_d_r <= 1'b1;
        end else begin
            pin_s1_r <= '{clk: norm_clk, oe_n: norm_oe_n,
                          d: parallel_data_inputs}; // RL10
            pin_s2_r <= pin_s1_r;
            nclk_d_r <= pin_s2_r.clk;
        end
    end

    // drive word arrives by toggle; its data holds long after each toggle
    always_ff @(posedge ref_clk or negedge ref_rst_n) begin
        if (!ref_rst_n) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
            drv_q_r  <= '{test: 1'b0, oe_n: 1'b1, q: 8'h00};
        end else begin
            tgl_s1_r <= tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
            if (tgl_s2_r != tgl_s3_r) begin
                drv_q_r <= drv_r;
            end
        end
    end

    // a rising pin clock with enable low queues one load
    assign f_in_valid  = pin_s2_r.clk && !nclk_d_r && !pin_s2_r.oe_n; // RL11
    // the queue stalls while test logic owns the outputs
    assign f_out_ready = !drv_q_r.test; // RL12

    orbst_fifo #(
        .W     (orbst_pkg::DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_load_fifo (
        .clk       (ref_clk),
        .rst_n     (ref_rst_n),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (pin_s2_r.d),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // output register: queue in normal mode, scan word in test mode
    always_ff @(posedge ref_clk or negedge ref_rst_n) begin
        if (!ref_rst_n) begin
            q_r    <= 8'h00;
            q_oe_r <= 1'b0;
            test_r <= 1'b0;
        end else begin
            test_r <= drv_q_r.test;
            if (drv_q_r.test) begin
                q_r    <= drv_q_r.q; // RL12
                q_oe_r <= !drv_q_r.oe_n;
            end else begin
                if (f_out_valid) begin
                    q_r <= f_out_data; // RL11
                end
                q_oe_r <= !pin_s2_r.oe_n; // RL11
            end
        end
    end

    // a load that finds the queue full is lost; sticky until reset
    always_ff @(posedge ref_clk or negedge ref_rst_n) begin
        if (!ref_rst_n) begin
            dropped_r <= 1'b0;
        end else if (f_in_valid && !f_in_ready) begin
            dropped_r <= 1'b1;
        end
    end

    assign parallel_data_outputs = q_r;
    assign pdo_oe                = q_oe_r;
    assign test_mode             = test_r;
    assign load_dropped          = dropped_r;

    // ------------------------------------------------------------------
    // test side: controller on tck
    // ------------------------------------------------------------------
    // pins and the output register are observed through two flops
    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            tpin_s1_r <= '1; // RL9
            tpin_s2_r <= '1;
            qobs_s1_r <= 8'h00;
            qobs_s2_r <= 8'h00;
            dh_s1_r   <= 1'b0;
            dh_s2_r   <= 1'b0;
        end else begin
            tpin_s1_r <= '{clk: norm_clk, oe_n: norm_oe_n,
                           d: parallel_data_inputs};
            tpin_s2_r <= tpin_s1_r;
            qobs_s1_r <= q_r;
            qobs_s2_r <= qobs_s1_r;
            dh_s1_r   <= mode_select_double_high_level;
            dh_s2_r   <= dh_s1_r;
        end
    end

    // next state from the mode select level alone
    always_comb begin
        state_nxt = state_r;
        unique case (state_r) // RL14
            orbst_pkg::ST_RESET:
                state_nxt = tms ? orbst_pkg::ST_RESET : orbst_pkg::ST_IDLE;
            orbst_pkg::ST_IDLE:
                state_nxt = tms ? orbst_pkg::ST_SEL_DR : orbst_pkg::ST_IDLE;
            orbst_pkg::ST_SEL_DR:
                state_nxt = tms ? orbst_pkg::ST_SEL_IR : orbst_pkg::ST_CAP_DR;
            orbst_pkg::ST_CAP_DR, orbst_pkg::ST_SHIFT_DR:
                state_nxt = tms ? orbst_pkg::ST_EXIT1_DR
                                : orbst_pkg::ST_SHIFT_DR;
            orbst_pkg::ST_EXIT1_DR:
                state_nxt = tms ? orbst_pkg::ST_UPD_DR
                                : orbst_pkg::ST_PAUSE_DR;
            orbst_pkg::ST_PAUSE_DR:
                state_nxt = tms ? orbst_pkg::ST_EXIT2_DR
                                : orbst_pkg::ST_PAUSE_DR;
            orbst_pkg::ST_EXIT2_DR:
                state_nxt = tms ? orbst_pkg::ST_UPD_DR
                                : orbst_pkg::ST_SHIFT_DR;
            orbst_pkg::ST_UPD_DR, orbst_pkg::ST_UPD_IR:
                state_nxt = tms ? orbst_pkg::ST_SEL_DR : orbst_pkg::ST_IDLE;
            orbst_pkg::ST_SEL_IR:
                state_nxt = tms ? orbst_pkg::ST_RESET : orbst_pkg::ST_CAP_IR;
            orbst_pkg::ST_CAP_IR, orbst_pkg::ST_SHIFT_IR:
                state_nxt = tms ? orbst_pkg::ST_EXIT1_IR
                                : orbst_pkg::ST_SHIFT_IR;
            orbst_pkg::ST_EXIT1_IR:
                state_nxt = tms ? orbst_pkg::ST_UPD_IR
                                : orbst_pkg::ST_PAUSE_IR;
            orbst_pkg::ST_PAUSE_IR:
                state_nxt = tms ? orbst_pkg::ST_EXIT2_IR
                                : orbst_pkg::ST_PAUSE_IR;
            orbst_pkg::ST_EXIT2_IR:
                state_nxt = tms ? orbst_pkg::ST_UPD_IR
                                : orbst_pkg::ST_SHIFT_IR;
        endcase
    end

    // the high-voltage level is asynchronous, so it is seen two edges late
    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            state_r <= orbst_pkg::ST_RESET;
        end else if (dh_s2_r) begin
            state_r <= orbst_pkg::ST_RESET; // RL5
        end else begin
            state_r <= state_nxt; // RL13 RL4
        end
    end

    // register selection decoded from the active instruction
    always_comb begin
        unique case (ir_q_r)
            orbst_pkg::OP_DRIVE_PINS, orbst_pkg::OP_SAMPLE:
                sel = orbst_pkg::SEL_BSR;
            orbst_pkg::OP_CONTROL:
                sel = orbst_pkg::SEL_BCR;
            default:
                sel = orbst_pkg::SEL_BYPASS;
        endcase
    end

    assign is_test_op = (ir_q_r == orbst_pkg::OP_DRIVE_PINS) ||
                        (ir_q_r == orbst_pkg::OP_FLOAT) ||
                        (ir_q_r == orbst_pkg::OP_HOLD);
    assign bsr_cap    = {qobs_s2_r, tpin_s2_r.d, tpin_s2_r.clk,
                         tpin_s2_r.oe_n};

    // instruction shift stage: fixed status on capture, tdi in at the top
    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            ir_sh_r <= orbst_pkg::IR_RESET;
        end else if (state_r == orbst_pkg::ST_CAP_IR) begin
            ir_sh_r <= orbst_pkg::IR_CAPTURE;
        end else if (state_r == orbst_pkg::ST_SHIFT_IR) begin
            ir_sh_r <= {tdi, ir_sh_r[7:1]}; // RL2 RL6 RL1
        end
    end

    // data shift stages; only the selected one moves
    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            bsr_sh_r <= '0;
            bcr_sh_r <= orbst_pkg::BCR_RESET;
            byp_sh_r <= 1'b0;
        end else if (state_r == orbst_pkg::ST_CAP_DR) begin
            unique case (sel)
                orbst_pkg::SEL_BSR:    bsr_sh_r <= bsr_cap;
                orbst_pkg::SEL_BCR:    bcr_sh_r <= bcr_q_r;
                default:               byp_sh_r <= 1'b0;
            endcase
        end else if (state_r == orbst_pkg::ST_SHIFT_DR) begin
            unique case (sel) // RL7 RL2
                orbst_pkg::SEL_BSR:    bsr_sh_r <= {tdi, bsr_sh_r[17:1]};
                orbst_pkg::SEL_BCR:    bcr_sh_r <= {tdi, bcr_sh_r[1]};
                default:               byp_sh_r <= tdi;
            endcase
        end
    end

    always_comb begin
        unique case (sel)
            orbst_pkg::SEL_BSR:    dr_lsb = bsr_sh_r[0];
            orbst_pkg::SEL_BCR:    dr_lsb = bcr_sh_r[0];
            default:               dr_lsb = byp_sh_r;
        endcase
    end

    // ------------------------------------------------------------------
    // test side: falling-edge update and output stages
    // ------------------------------------------------------------------
    // instruction and control take effect on the falling edge
    always_ff @(negedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            ir_q_r  <= orbst_pkg::IR_RESET;
            bcr_q_r <= orbst_pkg::BCR_RESET;
        end else if (state_r == orbst_pkg::ST_RESET) begin
            ir_q_r  <= orbst_pkg::IR_RESET;
            bcr_q_r <= orbst_pkg::BCR_RESET;
        end else if (state_r == orbst_pkg::ST_UPD_IR) begin
            ir_q_r <= ir_sh_r; // RL6
        end else if (state_r == orbst_pkg::ST_UPD_DR &&
                     sel == orbst_pkg::SEL_BCR) begin
            bcr_q_r <= bcr_sh_r;
        end
    end

    // boundary update latches hold across scans until the next update
    always_ff @(negedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            bsr_upd_r <= '{q: 8'h00, d: 8'h00, clk: 1'b1, oe_n: 1'b1};
        end else if (state_r == orbst_pkg::ST_UPD_DR &&
                     sel == orbst_pkg::SEL_BSR) begin
            bsr_upd_r <= bsr_sh_r;
        end
    end

    // serial output moves on the falling edge so tdo setup gets half a cycle
    always_ff @(negedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            tdo_r    <= 1'b1;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_oe_r <= (state_r == orbst_pkg::ST_SHIFT_IR) ||
                        (state_r == orbst_pkg::ST_SHIFT_DR); // RL3 RL1
            tdo_r    <= (state_r == orbst_pkg::ST_SHIFT_IR) ? ir_sh_r[0]
                                                           : dr_lsb; // RL3
        end
    end

    // drive word: normal-mode instructions never touch the pin side
    always_comb begin
        drv_nxt = '{test: is_test_op, oe_n: bsr_upd_r.oe_n, q: bsr_upd_r.q};
        if (ir_q_r == orbst_pkg::OP_FLOAT) begin
            drv_nxt.oe_n = 1'b1;
        end
        if (!is_test_op) begin
            drv_nxt = '{test: 1'b0, oe_n: 1'b1, q: 8'h00}; // RL15
        end
    end

    // one toggle per change; words change far slower than the crossing
    always_ff @(negedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            drv_r <= '{test: 1'b0, oe_n: 1'b1, q: 8'h00};
            tgl_r <= 1'b0;
        end else if (drv_nxt != drv_r) begin
            drv_r <= drv_nxt; // RL12
            tgl_r <= !tgl_r;
        end
    end

    assign tdo    = tdo_r;
    assign tdo_oe = tdo_oe_r;

endmodule
`default_nettype wire

/* File: test/orbst_checker.sv */
// Purpose: port-level checks of the boundary-scan octal register
// Assumes: tdo and tdo_oe move on falling tck only
// Notes:   bound to orbst_top below the module
`timescale 1ns/1ps
`default_nettype none
module orbst_checker (
    // clocks and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic tck,
    // watched pins
    input wire logic norm_oe_n,
    input wire logic tms,
    input wire logic mode_select_double_high_level,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic pdo_oe,
    input wire logic test_mode,
    input wire logic load_dropped
);
    // tdo just before each rise, so a change on the rise shows up
    logic tdo_seen_r;
    always_ff @(posedge tck) tdo_seen_r <= tdo;
    sequence s_tms_run; tms [*5]; endsequence
    sequence s_dbl_run; mode_select_double_high_level [*4]; endsequence
    chk_tdo_fall_only: assert property (@(negedge tck) disable iff (!rstn)
        tdo_oe |-> tdo == tdo_seen_r) else $error("tdo moved on rising tck");
    chk_tms_reset: assert property (@(posedge tck) disable iff (!rstn)
        s_tms_run |=> !tdo_oe) else $error("five tms highs kept tdo on");
    chk_dbl_reset: assert property (@(posedge tck) disable iff (!rstn)
        s_dbl_run |=> !tdo_oe) else $error("double high kept tdo on");
    chk_shift_entry: assert property (@(posedge tck) disable iff (!rstn)
        $rose(tdo_oe) |-> !$past(tms)) else $error("tdo on without tms low");
    chk_shift_exit: assert property (@(posedge tck) disable iff (!rstn)
        $fell(tdo_oe) |-> $past(tms) ||
            $past(mode_select_double_high_level, 3))
        else $error("tdo off without tms high");
    chk_shift_hold: assert property (@(posedge tck) disable iff (!rstn)
        tdo_oe && !tms && !mode_select_double_high_level |=> tdo_oe)
        else $error("tdo released inside shift");
    chk_oe_off: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(norm_oe_n) && !test_mode |-> ##[1:5] !pdo_oe)
        else $error("outputs not floated");
    chk_oe_on: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(norm_oe_n) && !test_mode |-> ##[1:5] pdo_oe)
        else $error("outputs not enabled");
    chk_drop_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
        load_dropped |=> load_dropped) else $error("drop flag cleared");
endmodule
bind orbst_top orbst_checker chk (.*);
`default_nettype wire

/* File: test/orbst_tester.sv */
// Purpose: test-bus controller on the four-wire serial test port
// Assumes: tdo_w already carries the pull-up while tdo is released
// Notes:   tck stands still between frames, 15 ns period inside them
`timescale 1ns/1ps
`default_nettype none
module orbst_tester (
    // serial test port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      dbl_high,
    input  wire logic tdo_w
);
    // idle levels of the bus
    initial begin
        {tck, tms, tdi, dbl_high} = 4'h6;
    end
    // one test clock: inputs move after the fall, tdo read at the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #7.5 tck = 1'h1;
        o = tdo_w;
        #7.5 tck = 1'h0;
    endtask
    // k clocks with tms held
    task automatic run(input int k, input logic m);
        logic o;
        repeat (k) step(m, ~tdi, o);
    endtask
    // forced test reset through the double-high level
    task automatic dbl(input logic v);
        dbl_high = v;
    endtask
    // idle to idle scan, lsb first
    task automatic scan(input logic ir, input int n,
                        input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        run(1 + 32'(ir), 1'h1);
        run(2, 1'h0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        run(1, 1'h1);
        run(1, 1'h0);
    endtask
endmodule
`default_nettype wire

/* File: test/orbst_top_tb.sv */
// Purpose: self-checking bench of the boundary-scan octal register
// Assumes: released tdo reads high through its pull-up
// Notes:   queue cut to four words so an overrun is quick
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module orbst_top_tb;
    localparam int DEPTH = 4;
    logic       ref_clk = 1'h0;
    logic       rstn, norm_clk, norm_oe_n, pdo_oe, tdo, tdo_oe;
    logic       tck, tms, tdi, dbl_high, test_mode, load_dropped;
    logic [7:0] pdi, pdo_q, v, qv;
    logic [7:0] w [DEPTH];
    logic [31:0] got;
    int         err_total = 0;
    int         compares = 0;
    wire        tdo_w = tdo_oe ? tdo : 1'h1;
    always #5 ref_clk = ~ref_clk;
    orbst_tester tester (.tck, .tms, .tdi, .dbl_high, .tdo_w);
    orbst_top #(.FIFO_DEPTH(DEPTH)) dut (.ref_clk, .rstn, .norm_clk,
        .norm_oe_n, .parallel_data_inputs(pdi),
        .parallel_data_outputs(pdo_q), .pdo_oe, .tck, .tms, .tdi,
        .mode_select_double_high_level(dbl_high), .tdo, .tdo_oe,
        .test_mode, .load_dropped);
    // register length behind an opcode
    function automatic int dr_len(input logic [7:0] op);
        if (op == orbst_pkg::OP_SAMPLE || op == orbst_pkg::OP_DRIVE_PINS)
            return orbst_pkg::BSR_LEN;
        return (op == orbst_pkg::OP_CONTROL) ? orbst_pkg::BCR_LEN : 1;
    endfunction
    task automatic summarize();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one pin load; clock pin held well past the synchroniser
    task automatic load(input logic [7:0] d);
        @(negedge ref_clk) pdi = d;
        repeat (3) @(negedge ref_clk);
        norm_clk = 1'h1;
        repeat (3) @(negedge ref_clk);
        norm_clk = 1'h0;
    endtask
    // bounded wait; a stuck value ends the run
    task automatic await(input logic [7:0] e);
        for (int i = 0; i < 20 && pdo_q !== e; i++) @(negedge ref_clk);
        `CHK(pdo_q, e)
        if (pdo_q !== e) summarize();
    endtask
    // extra bits prove the length
    task automatic set_ir(input logic [7:0] op);
        tester.scan(1'h1, 16, {16'h0, op, op}, got);
        `CHK(got, {16'h0, op, orbst_pkg::IR_CAPTURE})
    endtask
    task automatic scan_dr(input logic [7:0] op, input logic [31:0] cap);
        int n;
        logic [31:0] din;
        n = dr_len(op);
        din = $urandom;
        tester.scan(1'h0, n + 8, din, got);
        `CHK(got, (cap & ((32'h1 << n) - 32'h1)) | ({24'h0, din[7:0]} << n))
    endtask
    // main sequence; tck runs while reset is held and stands still at the release
    initial begin
        void'($urandom(90434));
        {rstn, norm_clk, norm_oe_n, pdi} = 11'h0;
        fork
            repeat (20) @(negedge ref_clk);
            tester.run(14, 1'h1);
        join
        @(negedge ref_clk) rstn = 1'h1;
        tester.run(5, 1'h1);
        tester.run(1, 1'h0);
        `CHK(tdo_oe, 1'h0)
        v = $urandom;
        load(v);
        await(v);
        `CHK(pdo_oe, 1'h1)
        norm_oe_n = 1'h1;
        load(~v);
        `CHK(pdo_oe, 1'h0)
        @(negedge ref_clk) norm_oe_n = 1'h0;
        scan_dr(orbst_pkg::OP_BYPASS, 32'h0);
        set_ir(orbst_pkg::OP_CONTROL);
        scan_dr(orbst_pkg::OP_CONTROL, 32'(orbst_pkg::BCR_RESET));
        set_ir(orbst_pkg::OP_SAMPLE);
        scan_dr(orbst_pkg::OP_SAMPLE, {14'h0, v, pdi, norm_clk, 1'h0});
        `CHK(pdo_q, v)
        qv = $urandom;
        set_ir(orbst_pkg::OP_DRIVE_PINS);
        tester.scan(1'h0, 26, {6'h0, qv, 18'h0}, got);
        for (int i = 0; i < DEPTH; i++) begin
            w[i] = 8'($urandom);
            load(w[i]);
        end
        load(8'h5a);
        `CHK({test_mode, pdo_oe, pdo_q}, {2'h3, qv})
        `CHK(load_dropped, 1'h1)
        set_ir(orbst_pkg::OP_FLOAT);
        repeat (10) @(negedge ref_clk);
        `CHK({test_mode, pdo_oe}, 2'h2)
        tester.dbl(1'h1);
        tester.run(4, 1'h0);
        tester.dbl(1'h0);
        tester.run(1, 1'h0);
        await(w[DEPTH - 1]);
        `CHK({test_mode, load_dropped}, 2'h1)
        summarize();
    end
endmodule
`default_nettype wire
